// [core/cdcpin_bank.sv]
// default pin configuration bank: one-time-programmable byte store, a
// load step after reset that fills the working registers, the io line
// function mux and the input change notifier.
// assumes all inputs are synchronous to clk_i and rstn_i is power-on reset.
// the store acts as fuses: set bits stay set,
// only otp_blank_i clears it.
// working registers load once, in the cycle
// after rstn_i rises; later writes wait for
// the next reset.
// pins are registered once after the mux, so
// they lag their sources by one clock.
// identifiers load without an override bit.
// the override bit 0 is not used here.
// the change notifier only flags; packet
// building and sending live elsewhere.
// reserved mode codes fall back to plain io.
`timescale 1ns/1ns

// Behaviour
// - mode low bit 7 drives clock on line 6
// - secondary 01: line 7 enables on transmit
// - secondary 10: line 7 enables on match
// - pin bit picks line 7 function source
// - primary 000: flow lines are plain io
// - primary 001: lines 5,4 RTS/CTS flow
// - primary 010: lines 2,3 DTR/DSR flow
// - primary 011: line 5 enables on transmit
// - primary 100: line 5 enables on match
// - mode high bit 1: line 9 rx toggle
// - mode high bit 0: line 8 tx toggle
// - direction low byte sets lines 7..0
// - direction high bits set lines 9,8
// - unmasked input change sends notification
// - masked input change sends nothing
// - baud limit built from three bytes
// - vendor id from two bytes, low first
// - product id from two bytes, low first
// - override bits gate replacing class defaults
// - blank reads zero; load after power-up
module cdcpin_bank (
   input wire logic clk_i, // core clock
   input wire logic rstn_i, // power-on reset, synchronous, low active
   input wire logic otp_blank_i, // clears the store to an unprogrammed part
   // configuration port
   input wire logic cfg_wr_i, // one-cycle write strobe
   input wire logic cfg_rd_i, // one-cycle read strobe
   input wire logic [8:0] cfg_addr_i, // byte offset
   input wire logic [7:0] cfg_wdata_i, // write byte
   output logic [7:0] cfg_rdata_o, // read byte, valid with cfg_rvalid_o
   output logic cfg_rvalid_o, // read answer pulse
   // load control
   input wire logic [4:0] override_en_i, // override-enable bits
   // io lines
   input wire logic [9:0] io_in_i, // io line levels
   output logic [9:0] io_out_o, // io line drive levels
   output logic [9:0] io_oe_o, // io line drive enables
   input wire logic [9:0] gpio_out_i, // general purpose output levels
   // function signals to and from the uart
   input wire logic clk_src_i, // clock to send out on line 6
   input wire logic tx_active_i, // uart is transmitting
   input wire logic addr_match_i, // multidrop address match in effect
   input wire logic rts_n_i, // automatic request-to-send level
   input wire logic dtr_n_i, // automatic terminal-ready level
   output logic cts_n_o, // clear-to-send level to the uart
   output logic dsr_n_o, // set-ready level to the uart
   input wire logic tx_toggle_i, // transmit activity toggle
   input wire logic rx_toggle_i, // receive activity toggle
   // change notifier
   output logic irq_req_o, // one-cycle request for a notification packet
   output logic [9:0] io_change_o, // lines that changed, with irq_req_o
   // working values
   output logic [23:0] baud_limit_o, // working low-latency baud threshold
   output logic [15:0] vendor_id_o, // working vendor identifier
   output logic [15:0] product_id_o, // working product identifier
   output logic load_done_o // working registers hold loaded values
);

   // offset decoding
   //
   // the bank is a contiguous run of offsets;
   // outside it writes drop, reads give zero.
   // true when the offset falls inside the bank
   function automatic logic in_bank(input logic [8:0] a);
      in_bank = (a >= cdcpin_pkg::OFS_PIN_FUNCTION_SELECT_LOW) &&
                (a <= cdcpin_pkg::OFS_PART_IDENT_HIGH);
   endfunction

   // bank index of an offset
   // only meaningful once in_bank agrees;
   // a low offset would wrap here.
   function automatic logic [3:0] bank_idx(input logic [8:0] a);
      logic [8:0] d;
      d = a - cdcpin_pkg::OFS_PIN_FUNCTION_SELECT_LOW;
      bank_idx = d[3:0];
   endfunction


   // storage and sequencing
   logic [7:0] bank [cdcpin_pkg::BANK_N]; // programmable store
   cdcpin_pkg::cdcpin_state_t state; // load sequencer

   // working copies, loaded once
   logic [7:0] mode_lo; // working mode low byte
   logic [7:0] mode_hi; // working mode high byte
   logic [9:0] dir; // working directions, 1 = output
   logic [9:0] mask; // working change masks, 1 = silent

   // change notifier state
   logic [9:0] io_prev; // io levels one cycle ago
   logic io_prev_ok; // io_prev holds a real sample

   // pin mux results
   logic [9:0] next_out; // mux result for drive levels
   logic [9:0] next_oe; // mux result for drive enables
   logic [9:0] func_in; // lines claimed as function inputs
   logic [9:0] changed; // unmasked input changes

   // fields of the low mode byte
   logic [2:0] pri; // primary pin mode field
   logic [1:0] sec; // secondary select field

   // store
   //
   // a write ORs its byte into the location;
   // no bit can be cleared but by blanking.
   // blanking wins over a write in one cycle.
   // no reset branch: rstn_i is a power cycle
   // and the fuses survive it.
   // store: programming only sets bits, as a fuse would; kept across reset
   always_ff @(posedge clk_i) begin
      // every location decodes its own write
      for (int i = 0; i < cdcpin_pkg::BANK_N; i++) begin
         if (otp_blank_i) begin
            bank[i] <= cdcpin_pkg::BANK_BLANK;
         end else if (cfg_wr_i && in_bank(cfg_addr_i) &&
                      (bank_idx(cfg_addr_i) == 4'(i))) begin
            bank[i] <= bank[i] | cfg_wdata_i;
         end
      end
   end

   // read port
   //
   // reads show the raw store, not the working
   // copies, so the host can verify a byte.
   // the byte stands until the next read.
   // read answer: bank bytes, zero for any other offset
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cfg_rdata_o <= 8'h00;
         cfg_rvalid_o <= 1'b0;
      end else begin
         // one answer per strobe, one clock later
         cfg_rvalid_o <= cfg_rd_i;
         if (cfg_rd_i && in_bank(cfg_addr_i)) begin
            cfg_rdata_o <= bank[bank_idx(cfg_addr_i)];
         end else if (cfg_rd_i) begin
            cfg_rdata_o <= 8'h00;
         end
      end
   end

   // load sequencer
   //
   // reset parks it in the load state, so the
   // first edge after release copies the store.
   // the run state never reloads.
   // load sequencer: one load cycle after release, then run for good
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state <= cdcpin_pkg::CDCPIN_LOAD;
      end else begin
         unique case (state)
            // one cycle only
            cdcpin_pkg::CDCPIN_LOAD: begin
               state <= cdcpin_pkg::CDCPIN_RUN;
            end
            // stays until the next reset
            cdcpin_pkg::CDCPIN_RUN: begin
               state <= cdcpin_pkg::CDCPIN_RUN;
            end
         endcase
      end
   end
   assign load_done_o = (state == cdcpin_pkg::CDCPIN_RUN);

   // working registers
   //
   // a group other than the identifiers takes the
   // stored bytes only if its override bit is high in the load cycle;
   // otherwise the class default stays.
   // the defaults are all zero for now.
   // working registers: class defaults unless the override bit is set; identifiers always load
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         mode_lo <= cdcpin_pkg::DEF_MODE_LO;
         mode_hi <= cdcpin_pkg::DEF_MODE_HI;
         dir <= cdcpin_pkg::DEF_DIR;
         mask <= cdcpin_pkg::DEF_MASK;
         baud_limit_o <= cdcpin_pkg::DEF_BAUD;
         vendor_id_o <= 16'h0000;
         product_id_o <= 16'h0000;
      end else if (state == cdcpin_pkg::CDCPIN_LOAD) begin
         // sampled once; the run state never reloads
         // pin mode bytes
         if (override_en_i[cdcpin_pkg::OVR_MODE]) begin
            mode_lo <= bank[cdcpin_pkg::IDX_MODE_LO];
            mode_hi <= bank[cdcpin_pkg::IDX_MODE_HI];
         end
         // direction bits, 1 = output
         if (override_en_i[cdcpin_pkg::OVR_DIR]) begin
            dir <= {bank[cdcpin_pkg::IDX_DIR_HI][1:0],
                    bank[cdcpin_pkg::IDX_DIR_LO]};
         end
         // change masks, 1 = silent
         if (override_en_i[cdcpin_pkg::OVR_MASK]) begin
            mask <= {bank[cdcpin_pkg::IDX_MASK_HI][1:0],
                     bank[cdcpin_pkg::IDX_MASK_LO]};
         end
         // low-latency baud limit
         if (override_en_i[cdcpin_pkg::OVR_BAUD]) begin
            baud_limit_o <= {bank[cdcpin_pkg::IDX_BAUD2], bank[cdcpin_pkg::IDX_BAUD1],
                             bank[cdcpin_pkg::IDX_BAUD0]};
         end
         // identifiers always load
         vendor_id_o <= {bank[cdcpin_pkg::IDX_VID_HI],
                         bank[cdcpin_pkg::IDX_VID_LO]};
         product_id_o <= {bank[cdcpin_pkg::IDX_PID_HI],
                          bank[cdcpin_pkg::IDX_PID_LO]};
      end
   end

   // field extraction
   assign pri = mode_lo[cdcpin_pkg::PRI_HI:0];
   assign sec = mode_lo[cdcpin_pkg::SEC_HI:cdcpin_pkg::SEC_LO];

   // pin function mux
   //
   // later assignments win, so a line claimed
   // twice by a bad program keeps the last.
   // 001 rts/cts on 5/4, 010 dtr/dsr on 2/3,
   // 011 and 100 drive line 5 as enable.
   // pin function mux: start from plain io, then lay functions on top
   always_comb begin
      next_out = gpio_out_i;
      next_oe = dir;
      func_in = 10'h000;
      // primary field; reserved codes fall through as plain io
      case (pri)
         // rts out on 5, cts in on 4
         cdcpin_pkg::PRI_RTS_CTS: begin
            next_out[cdcpin_pkg::LINE_RTS] = rts_n_i;
            next_oe[cdcpin_pkg::LINE_RTS] = 1'b1;
            next_oe[cdcpin_pkg::LINE_CTS] = 1'b0;
            func_in[cdcpin_pkg::LINE_CTS] = 1'b1;
         end
         // dtr out on 2, dsr in on 3
         cdcpin_pkg::PRI_DTR_DSR: begin
            next_out[cdcpin_pkg::LINE_DTR] = dtr_n_i;
            next_oe[cdcpin_pkg::LINE_DTR] = 1'b1;
            next_oe[cdcpin_pkg::LINE_DSR] = 1'b0;
            func_in[cdcpin_pkg::LINE_DSR] = 1'b1;
         end
         // enable while transmitting
         cdcpin_pkg::PRI_XCVR_TX: begin
            next_out[cdcpin_pkg::LINE_RTS] = tx_active_i;
            next_oe[cdcpin_pkg::LINE_RTS] = 1'b1;
         end
         // enable while address matches
         cdcpin_pkg::PRI_XCVR_ADDR: begin
            next_out[cdcpin_pkg::LINE_RTS] = addr_match_i;
            next_oe[cdcpin_pkg::LINE_RTS] = 1'b1;
         end
         // plain io, reserved codes too
         default: begin
            next_out = next_out;
         end
      endcase

      // line 7 follows the secondary field only when the pin bit is set
      if (mode_lo[cdcpin_pkg::BIT_SEC_PIN]) begin
         // code 11 is reserved: plain io
         if (sec == cdcpin_pkg::SEC_XCVR_TX) begin
            next_out[cdcpin_pkg::LINE_SEC] = tx_active_i;
            next_oe[cdcpin_pkg::LINE_SEC] = 1'b1;
         end else if (sec == cdcpin_pkg::SEC_XCVR_ADDR) begin
            next_out[cdcpin_pkg::LINE_SEC] = addr_match_i;
            next_oe[cdcpin_pkg::LINE_SEC] = 1'b1;
         end
      end

      // clock output on line 6
      if (mode_lo[cdcpin_pkg::BIT_CLK_EN]) begin
         next_out[cdcpin_pkg::LINE_CLK] = clk_src_i;
         next_oe[cdcpin_pkg::LINE_CLK] = 1'b1;
      end

      // transmit toggle on line 8
      if (mode_hi[cdcpin_pkg::BIT_TX_TOG]) begin
         next_out[cdcpin_pkg::LINE_TXT] = tx_toggle_i;
         next_oe[cdcpin_pkg::LINE_TXT] = 1'b1;
      end
      // receive toggle on line 9
      if (mode_hi[cdcpin_pkg::BIT_RX_TOG]) begin
         next_out[cdcpin_pkg::LINE_RXT] = rx_toggle_i;
         next_oe[cdcpin_pkg::LINE_RXT] = 1'b1;
      end
   end

   // pin registers
   //
   // the load cycle still sees default modes, so
   // drivers wait for the run state; otherwise an
   // input line could be driven for one clock.
   // reset leaves every line undriven.
   // io drive registers; lines stay undriven until loading is done
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         io_out_o <= 10'h000;
         io_oe_o <= 10'h000;
      end else if (state == cdcpin_pkg::CDCPIN_RUN) begin
         // pins follow the mux one clock late
         io_out_o <= next_out;
         io_oe_o <= next_oe;
      end
   end

   // flow inputs
   //
   // both are active low; an unclaimed line
   // reports one, so the uart never stops.
   // the level is taken from the pin as is.
   // flow inputs to the uart; idle high when the line is not claimed
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cts_n_o <= 1'b1;
         dsr_n_o <= 1'b1;
      end else begin
         cts_n_o <= func_in[cdcpin_pkg::LINE_CTS] ? io_in_i[cdcpin_pkg::LINE_CTS] : 1'b1;
         dsr_n_o <= func_in[cdcpin_pkg::LINE_DSR] ? io_in_i[cdcpin_pkg::LINE_DSR] : 1'b1;
      end
   end

   // change notifier
   //
   // driven lines are left out: their level is
   // ours and tells the host nothing.
   // io_prev_ok hides the first run cycle,
   // when io_prev predates the loaded mode.
   // change notifier: only input lines whose mask bit is clear report
   assign changed = (io_in_i ^ io_prev) & ~next_oe & ~mask & {10{io_prev_ok}};

   // one pulse per clock with a change; bursts
   // are merged by the packet builder.
   // previous levels and notification pulse
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         io_prev <= 10'h000;
         io_prev_ok <= 1'b0;
         irq_req_o <= 1'b0;
         io_change_o <= 10'h000;
      end else begin
         // sample every clock
         io_prev <= io_in_i;
         io_prev_ok <= (state == cdcpin_pkg::CDCPIN_RUN);
         // pulse and line set go out together
         irq_req_o <= |changed;
         io_change_o <= changed;
      end
   end
endmodule

// [core/cdcpin_pkg.sv]
// package for the default pin configuration bank: byte offsets, field
// positions, reset values and encodings shared by the bank and its bench.
// assumes a byte-wide configuration port and a ten-line io bank.
package cdcpin_pkg;
   // address width of the configuration port, io line count and bank size
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned NUM_IO = 10;
   localparam int unsigned BANK_N = 13;

   // byte offsets of the bank locations
   localparam logic [8:0] OFS_PIN_FUNCTION_SELECT_LOW = 9'h009;
   localparam logic [8:0] OFS_PIN_FUNCTION_SELECT_HIGH = 9'h00a;
   localparam logic [8:0] OFS_IO_DIRECTION_LOW = 9'h00b;
   localparam logic [8:0] OFS_IO_DIRECTION_HIGH = 9'h00c;
   localparam logic [8:0] OFS_IO_CHANGE_MASK_LOW = 9'h00d;
   localparam logic [8:0] OFS_IO_CHANGE_MASK_HIGH = 9'h00e;
   localparam logic [8:0] OFS_LATENCY_BAUD_LIMIT_BYTE0 = 9'h00f;
   localparam logic [8:0] OFS_LATENCY_BAUD_LIMIT_BYTE1 = 9'h010;
   localparam logic [8:0] OFS_LATENCY_BAUD_LIMIT_BYTE2 = 9'h011;
   localparam logic [8:0] OFS_MAKER_IDENT_LOW = 9'h012;
   localparam logic [8:0] OFS_MAKER_IDENT_HIGH = 9'h013;
   localparam logic [8:0] OFS_PART_IDENT_LOW = 9'h014;
   localparam logic [8:0] OFS_PART_IDENT_HIGH = 9'h015;

   // bank index of each location (offset minus the first offset)
   localparam logic [3:0] IDX_MODE_LO = 4'h0;
   localparam logic [3:0] IDX_MODE_HI = 4'h1;
   localparam logic [3:0] IDX_DIR_LO = 4'h2;
   localparam logic [3:0] IDX_DIR_HI = 4'h3;
   localparam logic [3:0] IDX_MASK_LO = 4'h4;
   localparam logic [3:0] IDX_MASK_HI = 4'h5;
   localparam logic [3:0] IDX_BAUD0 = 4'h6;
   localparam logic [3:0] IDX_BAUD1 = 4'h7;
   localparam logic [3:0] IDX_BAUD2 = 4'h8;
   localparam logic [3:0] IDX_VID_LO = 4'h9;
   localparam logic [3:0] IDX_VID_HI = 4'ha;
   localparam logic [3:0] IDX_PID_LO = 4'hb;
   localparam logic [3:0] IDX_PID_HI = 4'hc;

   // field positions in the mode low byte
   localparam int unsigned BIT_CLK_EN = 7;
   localparam int unsigned SEC_HI = 6;
   localparam int unsigned SEC_LO = 5;
   localparam int unsigned BIT_SEC_PIN = 4;
   localparam int unsigned PRI_HI = 2;
   // field positions in the mode high byte
   localparam int unsigned BIT_RX_TOG = 1;
   localparam int unsigned BIT_TX_TOG = 0;

   // override-enable bit positions
   localparam int unsigned OVR_MODE = 1;
   localparam int unsigned OVR_DIR = 2;
   localparam int unsigned OVR_MASK = 3;
   localparam int unsigned OVR_BAUD = 4;

   // primary pin mode encodings
   localparam logic [2:0] PRI_GPIO = 3'h0;
   localparam logic [2:0] PRI_RTS_CTS = 3'h1;
   localparam logic [2:0] PRI_DTR_DSR = 3'h2;
   localparam logic [2:0] PRI_XCVR_TX = 3'h3;
   localparam logic [2:0] PRI_XCVR_ADDR = 3'h4;
   // secondary select encodings
   localparam logic [1:0] SEC_GPIO = 2'h0;
   localparam logic [1:0] SEC_XCVR_TX = 2'h1;
   localparam logic [1:0] SEC_XCVR_ADDR = 2'h2;

   // io line numbers used by the pin functions
   localparam int unsigned LINE_DTR = 2;
   localparam int unsigned LINE_DSR = 3;
   localparam int unsigned LINE_CTS = 4;
   localparam int unsigned LINE_RTS = 5;
   localparam int unsigned LINE_CLK = 6;
   localparam int unsigned LINE_SEC = 7;
   localparam int unsigned LINE_TXT = 8;
   localparam int unsigned LINE_RXT = 9;

   // values after reset and built-in class defaults (plain values)
   localparam logic [7:0] BANK_BLANK = 8'h00;
   localparam logic [7:0] DEF_MODE_LO = 8'h00;
   localparam logic [7:0] DEF_MODE_HI = 8'h00;
   localparam logic [9:0] DEF_DIR = 10'h000;
   localparam logic [9:0] DEF_MASK = 10'h000;
   localparam logic [23:0] DEF_BAUD = 24'h000000;

   // load sequencer states
   typedef enum logic [0:0] {
      CDCPIN_LOAD = 1'b0,
      CDCPIN_RUN = 1'b1
   } cdcpin_state_t;
endpackage

// [bench/cdcpin_props.sv]
// assertions on the ports of the default pin configuration bank
// assumes one clock domain and a bind onto every cdcpin_bank instance
`timescale 1ns/1ns
module cdcpin_props (
   input wire logic clk_i, // core clock
   input wire logic rstn_i, // sync reset, low active
   input wire logic cfg_rd_i, // read strobe
   input wire logic [7:0] cfg_rdata_o, // read byte
   input wire logic cfg_rvalid_o, // read answer pulse
   input wire logic [9:0] io_in_i, // io line levels
   input wire logic [9:0] io_oe_o, // drive enables
   input wire logic irq_req_o, // notification pulse
   input wire logic [9:0] io_change_o, // changed lines
   input wire logic load_done_o // working values loaded
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // a read is answered exactly one cycle later
   sequence s_read;
      cfg_rd_i ##1 cfg_rvalid_o;
   endsequence
   // release of reset, then one load cycle
   sequence s_load;
      $rose(rstn_i) ##0 !load_done_o ##1 load_done_o;
   endsequence
   a_read_answer: assert property (cfg_rd_i |-> s_read)
      else $error("read not answered");
   a_answer_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i))
      else $error("answer without read");
   a_rdata_holds: assert property ($past(rstn_i) && !cfg_rvalid_o |-> $stable(cfg_rdata_o))
      else $error("read byte moved");
   a_load_first: assert property ($rose(rstn_i) |-> s_load)
      else $error("no load after reset");
   a_load_stays: assert property (load_done_o |=> load_done_o)
      else $error("load flag dropped");
   a_irq_lines: assert property (irq_req_o |-> io_change_o != 10'h000)
      else $error("notification without lines");
   a_irq_real: assert property (irq_req_o |->
      (io_change_o & ~($past(io_in_i) ^ $past(io_in_i, 2))) == 10'h000)
      else $error("line reported without change");
   a_irq_inputs: assert property (irq_req_o |-> (io_change_o & io_oe_o) == 10'h000)
      else $error("driven line reported");
   a_quiet_no_irq: assert property ($past(io_in_i) == $past(io_in_i, 2) |-> !irq_req_o)
      else $error("notification without change");
endmodule

bind cdcpin_bank cdcpin_props u_props (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_rd_i(cfg_rd_i),
   .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .io_in_i(io_in_i),
   .io_oe_o(io_oe_o), .irq_req_o(irq_req_o), .io_change_o(io_change_o),
   .load_done_o(load_done_o));

// [bench/cdcpin_host.sv]
// host model that programs and reads the bank over the byte config port
// assumes the bank clock; strobes change only just after a rising edge
`timescale 1ns/1ns
module cdcpin_host (
   input wire logic clk_i, // core clock
   input wire logic [7:0] cfg_rdata_i, // read byte
   input wire logic cfg_rvalid_i, // read answer
   output logic cfg_wr_o, // write strobe
   output logic cfg_rd_o, // read strobe
   output logic [8:0] cfg_addr_o, // byte offset
   output logic [7:0] cfg_wdata_o // write byte
);
   // idle port at time zero
   initial begin
      cfg_wr_o = 1'b0;
      cfg_rd_o = 1'b0;
      cfg_addr_o = 9'h000;
      cfg_wdata_o = 8'h00;
   end
   // one byte write; unless raw, bytes for 00a, 00c and 00e are cut to their two low bits
   task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic raw);
      logic [7:0] v;
      v = d;
      if (!raw && (a == 9'h00a || a == 9'h00c || a == 9'h00e)) begin
         v = d & 8'h03;
      end
      @(posedge clk_i);
      cfg_wr_o <= 1'b1;
      cfg_addr_o <= a;
      cfg_wdata_o <= v;
      @(posedge clk_i);
      cfg_wr_o <= 1'b0;
      cfg_addr_o <= ~a;
      cfg_wdata_o <= ~v;
   endtask
   // one byte read; the answer is taken just after the edge that launches it
   task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk_i);
      cfg_rd_o <= 1'b1;
      cfg_addr_o <= a;
      @(posedge clk_i);
      cfg_rd_o <= 1'b0;
      cfg_addr_o <= ~a;
      #1;
      ok = cfg_rvalid_i;
      d = cfg_rdata_i;
   endtask
endmodule

// [bench/test_cdc_default_pin_config_bank.sv]
// self-checking bench for the default pin configuration bank
// assumes cdcpin_host as programming host and the bound checker
`timescale 1ns/1ns
module test_cdc_default_pin_config_bank;
   logic clk_i, rstn_i, otp_blank_i, clk_src_i, tx_active_i, addr_match_i, ok;
   logic rts_n_i, dtr_n_i, tx_toggle_i, rx_toggle_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o;
   logic cts_n_o, dsr_n_o, irq_req_o, load_done_o;
   logic [8:0] cfg_addr_i;
   logic [7:0] cfg_wdata_i, cfg_rdata_o, rd_v;
   logic [4:0] override_en_i;
   logic [9:0] io_in_i, io_out_o, io_oe_o, gpio_out_i, io_change_o;
   logic [23:0] baud_limit_o;
   logic [15:0] vendor_id_o, product_id_o;
   int fails, checked;
   typedef struct packed {logic [8:0] a; logic [7:0] d; logic [7:0] q;} cdcpin_row_t;
   // offset, byte written, byte read back; the last offset is unmapped
   cdcpin_row_t rows [14] = '{'{9'h009, 8'hb1, 8'hb1}, '{9'h00a, 8'h03, 8'h03},
      '{9'h00b, 8'h02, 8'h02}, '{9'h00c, 8'h00, 8'h00}, '{9'h00d, 8'h01, 8'h01},
      '{9'h00e, 8'h00, 8'h00}, '{9'h00f, 8'h12, 8'h12}, '{9'h010, 8'h34, 8'h34},
      '{9'h011, 8'h56, 8'h56}, '{9'h012, 8'h2c, 8'h2c}, '{9'h013, 8'h4d, 8'h4d},
      '{9'h014, 8'h91, 8'h91}, '{9'h015, 8'h7e, 8'h7e}, '{9'h016, 8'hff, 8'h00}};
   // primary codes and expected {oe[5:2], out[5], dsr}
   logic [2:0] codes [4] = '{cdcpin_pkg::PRI_GPIO, cdcpin_pkg::PRI_DTR_DSR,
      cdcpin_pkg::PRI_XCVR_TX, cdcpin_pkg::PRI_XCVR_ADDR};
   logic [5:0] mexp [4] = '{6'h03, 6'h06, 6'h23, 6'h21};
   cdcpin_bank DUT (.clk_i(clk_i), .rstn_i(rstn_i), .otp_blank_i(otp_blank_i),
      .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
      .override_en_i(override_en_i), .io_in_i(io_in_i), .io_out_o(io_out_o),
      .io_oe_o(io_oe_o), .gpio_out_i(gpio_out_i), .clk_src_i(clk_src_i),
      .tx_active_i(tx_active_i), .addr_match_i(addr_match_i), .rts_n_i(rts_n_i),
      .dtr_n_i(dtr_n_i), .cts_n_o(cts_n_o), .dsr_n_o(dsr_n_o), .tx_toggle_i(tx_toggle_i),
      .rx_toggle_i(rx_toggle_i), .irq_req_o(irq_req_o), .io_change_o(io_change_o),
      .baud_limit_o(baud_limit_o), .vendor_id_o(vendor_id_o),
      .product_id_o(product_id_o), .load_done_o(load_done_o));
   cdcpin_host host (.clk_i(clk_i), .cfg_rdata_i(cfg_rdata_o), .cfg_rvalid_i(cfg_rvalid_o),
      .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i),
      .cfg_wdata_o(cfg_wdata_i));
   // 25 MHz core clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // compare one value, case equality so unknowns fail
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // counts, verdict, end of run
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // reset for n edges, wait boundedly for the load, let the mux settle
   task automatic reboot(input int n);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 8 && load_done_o !== 1'b1; i++) @(posedge clk_i);
      if (load_done_o !== 1'b1) begin
         fails++;
         wrap_up();
      end
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // erase the store to an unprogrammed part
   task automatic blank();
      @(posedge clk_i);
      otp_blank_i <= 1'b1;
      @(posedge clk_i);
      otp_blank_i <= 1'b0;
   endtask
   // main sequence
   initial begin
      rstn_i = 1'b0;
      otp_blank_i = 1'b1;
      override_en_i = 5'h00;
      io_in_i = 10'h000;
      gpio_out_i = 10'h3ff;
      clk_src_i = 1'b1;
      tx_active_i = 1'b1;
      addr_match_i = 1'b0;
      rts_n_i = 1'b0;
      dtr_n_i = 1'b0;
      tx_toggle_i = 1'b1;
      rx_toggle_i = 1'b1;
      repeat (2) @(posedge clk_i);
      otp_blank_i <= 1'b0;
      reboot(17);
      foreach (rows[i]) begin
         host.rd(rows[i].a, rd_v, ok);
         chk(ok, 1'b1);
         chk(rd_v, 8'h00);
         host.wr(rows[i].a, rows[i].d, 1'b0);
         host.rd(rows[i].a, rd_v, ok);
         chk(rd_v, rows[i].q);
      end
      chk(baud_limit_o, 24'h000000);
      override_en_i <= 5'h1e;
      reboot(2);
      chk(baud_limit_o, 24'h563412);
      chk(vendor_id_o, 16'h4d2c);
      chk(product_id_o, 16'h7e91);
      chk(io_oe_o, 10'h3e2);
      chk(io_out_o & 10'h3ef, 10'h3cf);
      chk({cts_n_o, dsr_n_o}, 2'b01);
      tx_active_i <= 1'b0;
      rts_n_i <= 1'b1;
      clk_src_i <= 1'b0;
      tx_toggle_i <= 1'b0;
      rx_toggle_i <= 1'b0;
      io_in_i <= 10'h010;
      repeat (2) @(posedge clk_i);
      #1;
      chk(io_out_o[7:5], 3'b001);
      chk(io_out_o[6], 1'b0);
      chk(io_out_o[8], 1'b0);
      chk(io_out_o[9], 1'b0);
      chk(cts_n_o, 1'b1);
      @(posedge clk_i);
      io_in_i <= io_in_i ^ 10'h008;
      @(posedge clk_i);
      #1;
      chk({irq_req_o, io_change_o}, 11'h408);
      @(posedge clk_i);
      io_in_i <= io_in_i ^ 10'h003;
      @(posedge clk_i);
      #1;
      chk(irq_req_o, 1'b0);
      override_en_i <= 5'h00;
      reboot(2);
      chk(baud_limit_o, cdcpin_pkg::DEF_BAUD);
      chk(io_oe_o, cdcpin_pkg::DEF_DIR);
      host.wr(9'h009, 8'h04, 1'b1);
      override_en_i <= 5'h1e;
      reboot(2);
      chk({io_oe_o[5], cts_n_o}, 2'b01);
      tx_active_i <= 1'b1;
      io_in_i <= 10'h000;
      for (int m = 0; m < 4; m++) begin
         blank();
         host.wr(9'h009, {5'b01010, codes[m]}, 1'b0);
         reboot(2);
         chk({io_oe_o[5:2], io_out_o[5], dsr_n_o}, mexp[m]);
         chk({io_oe_o[7], io_out_o[7]}, 2'b10);
      end
      addr_match_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk({io_out_o[7], io_out_o[5]}, 2'b11);
      wrap_up();
   end
endmodule
